// file: lasi_clock_watch.sv
/*
 * Transmit clock loss watchdog: flags a transmit clock that has not
 * toggled for more than the loss count of master clock cycles.
 * Assumes tx_clk_sync has already passed a two-flop synchroniser.
 */
`timescale 1ns/100ps
module lasi_clock_watch
    import lasi_pkg::*;
#(
    parameter int LOSS_CYC = LASI_TXCLK_LOSS_CYC
)(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Synchronised transmit clock
    input  wire logic tx_clk_sync,
    // Loss level
    output logic      tx_clock_missing
);

    // ========================================================================
    // Quiet-time counter
    // ========================================================================
    localparam int CW = $clog2(LOSS_CYC + 2);

    // Elaboration guard: a zero limit would flag loss between toggles
    if (LOSS_CYC < 1) begin : g_bad_loss
        $error("lasi_clock_watch: LOSS_CYC must be at least 1");
    end

    logic          last_ff;
    logic [CW-1:0] quiet_ff;
    logic          miss_ff;

    // Any toggle restarts the count; the count saturates past the limit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_ff  <= 1'b0;
            quiet_ff <= '0;
        end else begin
            last_ff <= tx_clk_sync;
            if (tx_clk_sync != last_ff) begin
                quiet_ff <= '0;
            end else if (quiet_ff <= CW'(LOSS_CYC)) begin
                quiet_ff <= quiet_ff + CW'(1);
            end
        end
    end

    // More than the limit without a toggle means loss
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            miss_ff <= 1'b0;
        end else begin
            miss_ff <= (quiet_ff >= CW'(LOSS_CYC)) && (tx_clk_sync == last_ff);
        end
    end

    assign tx_clock_missing = miss_ff;

endmodule : lasi_clock_watch

// file: lasi_edge_event.sv
/*
 * Turns one live status level into a one-cycle interrupt event.
 * Assumes the level is already synchronous to ref_clk.
 */
`timescale 1ns/100ps
module lasi_edge_event
    import lasi_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Level and its controls
    input  wire logic level,
    input  wire logic mask,
    input  wire logic edge_sel,
    // Event out
    output logic      event_pulse
);

    // ========================================================================
    // Edge detection
    // ========================================================================
    logic prev_ff;

    // Previous level; resets low so a level high at reset counts as rising
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= level;
        end
    end

    // Rising only, or any change, and only when unmasked
    assign event_pulse = !mask && (edge_sel ? (level ^ prev_ff) : (level && !prev_ff));

endmodule : lasi_edge_event

// file: lasi_host_model.sv
/*
 * Host model on the control port: one-cycle read strobes and interrupt
 * service. Assumes its tasks are entered just after a ref_clk rising edge.
 */
`timescale 1ns/100ps
module lasi_host_model (
    // Clock
    input  wire logic       ref_clk,
    // Read port toward the block
    output logic            rd_stb,
    output logic [7:0]      rd_addr,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_hit
);
    // Idle port at time zero
    initial begin
        rd_stb  = 1'b0;
        rd_addr = 8'h00;
    end

    // One read; address scrambled after release so stale values are never trusted
    task automatic do_read(input logic [7:0] addr, output logic [7:0] data, output logic hit);
        rd_stb  <= 1'b1;
        rd_addr <= addr;
        @(posedge ref_clk);
        rd_stb  <= 1'b0;
        rd_addr <= ~addr;
        @(posedge ref_clk);
        data = rd_data;
        hit  = rd_hit;
    endtask : do_read

    // Interrupt service reads both event registers: a read destroys them
    task automatic service(input logic [7:0] base, output logic [7:0] prim, output logic [7:0] sec);
        logic hit;
        do_read(base + 8'h18, prim, hit);
        do_read(base + 8'h19, sec, hit);
    endtask : service
endmodule : lasi_host_model

// file: lasi_pkg.sv
/*
 * Package for the line alarm status and interrupt block: register offsets,
 * field positions, reset values, timing counts and shared types.
 * Assumes a single 20 MHz system clock and an 8-bit control port.
 */
package lasi_pkg;

    // ========================================================================
    // Register map (channel one base, channel two adds the channel stride)
    // ========================================================================
    localparam logic [7:0] LASI_OFS_LINE_ALARM_LIVE      = 8'h16;
    localparam logic [7:0] LASI_OFS_LOOPBACK_ATTEN_LIVE  = 8'h17;
    localparam logic [7:0] LASI_OFS_EVENT_LATCH_PRIMARY  = 8'h18;
    localparam logic [7:0] LASI_OFS_EVENT_LATCH_SECONDARY = 8'h19;
    localparam logic [7:0] LASI_CHAN_STRIDE              = 8'h20;

    // ========================================================================
    // Field positions
    // ========================================================================
    localparam int LASI_BIT_EQ       = 7;
    localparam int LASI_BIT_IBLA     = 6;
    localparam int LASI_BIT_IBLD     = 5;
    localparam int LASI_BIT_PSYNC    = 4;
    localparam int LASI_BIT_TXCLK    = 3;
    localparam int LASI_BIT_DRVF     = 2;
    localparam int LASI_BIT_AIS      = 1;
    localparam int LASI_BIT_LOS      = 0;
    localparam int LASI_BIT_RLOOP    = 5;
    localparam int LASI_ATTEN_MSB    = 4;
    localparam int LASI_ATTEN_W      = 5;

    // ========================================================================
    // Reset values and timing
    // ========================================================================
    localparam logic [7:0] LASI_RST_BYTE      = 8'h00;
    localparam logic [4:0] LASI_ATTEN_MAX_LISTED = 5'h15;  // 42 to 44 dB step
    localparam int         LASI_TXCLK_LOSS_CYC = 70;       // master clock cycles

    // Live levels sampled from the line and detector side, per channel
    typedef struct packed {
        logic       equalizer_out;
        logic       inband_activate;
        logic       inband_deactivate;
        logic       pattern_sync;
        logic       driver_fault_level;
        logic       alarm_indication_seen;
        logic       signal_lost_flag;
        logic       remote_loopback_active;
        logic [4:0] line_attenuation_code;
    } lasi_live_t;

    // Single-cycle events from other blocks, secondary register layout
    typedef struct packed {
        logic waveform_amplitude_overflow_event;
        logic jitter_buffer_overflow_event;
        logic jitter_buffer_underflow_event;
        logic pattern_error_event;
        logic excess_zeros_event;
        logic code_violation_event;
        logic one_second_tick_event;
        logic counter_wrap_event;
    } lasi_pulse_t;

    // Per-source mask and edge select, primary register layout
    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] edge_sel;
    } lasi_irq_cfg_t;

endpackage : lasi_pkg

// file: lasi_status_irq.sv
/*
 * Two-channel line status and latched interrupt status block. Holds the
 * live alarm and attenuation registers and the clear-on-read event
 * registers, and drives one interrupt request.
 * Assumes a one-cycle read strobe from the control port decoder on ref_clk,
 * detector levels and tx clocks from outside the clock domain, and event
 * pulses from logic on ref_clk.
 */
`timescale 1ns/100ps
module lasi_status_irq
    import lasi_pkg::*;
#(
    parameter int NUM_CH   = 2,
    parameter int LOSS_CYC = LASI_TXCLK_LOSS_CYC
)(
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    // Control port read access
    input  wire logic                rd_stb,
    input  wire logic [7:0]          rd_addr,
    output logic      [7:0]          rd_data,
    output logic                     rd_hit,
    // Detector levels and transmit clocks, asynchronous
    input  wire lasi_live_t [NUM_CH-1:0]  live_in,
    input  wire logic [NUM_CH-1:0]   tx_clk_in,
    // Event pulses from logic on ref_clk
    input  wire lasi_pulse_t [NUM_CH-1:0] pulse_in,
    // Masks and edge selects from the configuration registers
    input  wire lasi_irq_cfg_t [NUM_CH-1:0] irq_cfg,
    input  wire logic [NUM_CH-1:0] [7:0] sec_mask,
    // Interrupt request
    output logic                     irq_req
);

    // Elaboration guard: the decode knows only two channel windows
    if (NUM_CH < 1 || NUM_CH > 2) begin : g_bad_ch
        $error("lasi_status_irq: NUM_CH must be 1 or 2");
    end

    // ========================================================================
    // Reset release
    // ========================================================================
    logic rst_meta_ff;
    logic rst_sync_ff;

    // Release is synchronous so every flop reset by rst_sync_ff leaves reset on the same edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ========================================================================
    // Address decode
    // ========================================================================
    // Returns channel index plus one for a hit on this register, zero on miss
    function automatic logic [1:0] ch_hit(input logic [7:0] addr, input logic [7:0] ofs);
        logic [1:0] r;
        r = 2'h0;
        if (addr == ofs) begin
            r = 2'h1;
        end else if (NUM_CH > 1 && addr == ofs + LASI_CHAN_STRIDE) begin
            r = 2'h2;
        end
        return r;
    endfunction : ch_hit

    logic [1:0] hit_a;
    logic [1:0] hit_b;
    logic [1:0] hit_p;
    logic [1:0] hit_s;

    assign hit_a = ch_hit(rd_addr, LASI_OFS_LINE_ALARM_LIVE);
    assign hit_b = ch_hit(rd_addr, LASI_OFS_LOOPBACK_ATTEN_LIVE);
    assign hit_p = ch_hit(rd_addr, LASI_OFS_EVENT_LATCH_PRIMARY);
    assign hit_s = ch_hit(rd_addr, LASI_OFS_EVENT_LATCH_SECONDARY);

    // ========================================================================
    // Per-channel logic
    // ========================================================================
    logic [NUM_CH-1:0] [7:0] line_alarm_live;
    logic [NUM_CH-1:0] [7:0] loopback_attenuation_live;
    logic [NUM_CH-1:0] [7:0] event_latch_primary;
    logic [NUM_CH-1:0] [7:0] event_latch_secondary;
    logic [NUM_CH-1:0]       ch_irq;

    genvar c;
    genvar b;
    generate
        for (c = 0; c < NUM_CH; c++) begin : g_ch
            lasi_live_t live_meta_ff;
            lasi_live_t live_ff;
            logic       txc_meta_ff;
            logic       txc_ff;
            logic       tx_clock_missing;
            logic [7:0] lvl;
            logic [7:0] edge_evt;
            logic [7:0] pri_ff;
            logic [7:0] sec_ff;
            logic       clr_pri;
            logic       clr_sec;

            // Two-flop synchronisers for detector levels and the tx clock
            always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
                if (!rst_sync_ff) begin
                    live_meta_ff <= '0;
                    live_ff      <= '0;
                    txc_meta_ff  <= 1'b0;
                    txc_ff       <= 1'b0;
                end else begin
                    live_meta_ff <= live_in[c];
                    live_ff      <= live_meta_ff;
                    txc_meta_ff  <= tx_clk_in[c];
                    txc_ff       <= txc_meta_ff;
                end
            end

            lasi_clock_watch #(
                .LOSS_CYC (LOSS_CYC)
            ) u_watch (
                .ref_clk          (ref_clk),
                .rst_n            (rst_sync_ff),
                .tx_clk_sync      (txc_ff),
                .tx_clock_missing (tx_clock_missing)
            );

            // Live levels in primary-register bit order
            assign lvl = {live_ff.equalizer_out, live_ff.inband_activate,
                          live_ff.inband_deactivate, live_ff.pattern_sync,
                          tx_clock_missing, live_ff.driver_fault_level,
                          live_ff.alarm_indication_seen, live_ff.signal_lost_flag};

            // First status register shows the live levels
            assign line_alarm_live[c] = lvl;

            // Reserved bits forced low, loopback and attenuation live
            assign loopback_attenuation_live[c] = {2'b00, live_ff.remote_loopback_active,
                                                   live_ff.line_attenuation_code};

            // One edge detector per live level
            for (b = 0; b < 8; b++) begin : g_edge
                lasi_edge_event u_edge (
                    .ref_clk     (ref_clk),
                    .rst_n       (rst_sync_ff),
                    .level       (lvl[b]),
                    .mask        (irq_cfg[c].mask[b]),
                    .edge_sel    (irq_cfg[c].edge_sel[b]),
                    .event_pulse (edge_evt[b])
                );
            end

            assign clr_pri = rd_stb && (hit_p == 2'(c + 1));
            assign clr_sec = rd_stb && (hit_s == 2'(c + 1));

            // Primary latch: a set in the clearing cycle survives the read
            always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
                if (!rst_sync_ff) begin
                    pri_ff <= LASI_RST_BYTE;
                end else begin
                    pri_ff <= (clr_pri ? 8'h00 : pri_ff) | edge_evt;
                end
            end

            // Secondary latch; pulses arrive already on ref_clk
            always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
                if (!rst_sync_ff) begin
                    sec_ff <= LASI_RST_BYTE;
                end else begin
                    sec_ff <= (clr_sec ? 8'h00 : sec_ff) | pulse_in[c];
                end
            end

            assign event_latch_primary[c]   = pri_ff;
            assign event_latch_secondary[c] = sec_ff;
            // Primary bits were gated at the edge; secondary gated here
            assign ch_irq[c] = (|pri_ff) || (|(sec_ff & ~sec_mask[c]));
        end
    endgenerate

    // ========================================================================
    // Read data and interrupt request
    // ========================================================================
    logic [7:0] nxt_rd_data;
    logic [7:0] rd_data_ff;
    logic       nxt_rd_hit;
    logic       rd_hit_ff;
    logic       irq_ff;

    // Mux returns the pre-clear value of an event register
    always_comb begin
        nxt_rd_data = 8'h00;
        nxt_rd_hit  = 1'b1;
        if (hit_a != 2'h0) begin
            nxt_rd_data = line_alarm_live[hit_a - 2'h1];
        end else if (hit_b != 2'h0) begin
            nxt_rd_data = loopback_attenuation_live[hit_b - 2'h1];
        end else if (hit_p != 2'h0) begin
            nxt_rd_data = event_latch_primary[hit_p - 2'h1];
        end else if (hit_s != 2'h0) begin
            nxt_rd_data = event_latch_secondary[hit_s - 2'h1];
        end else begin
            nxt_rd_hit = 1'b0;
        end
    end

    // Read data registered one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            rd_data_ff <= 8'h00;
            rd_hit_ff  <= 1'b0;
        end else if (rd_stb) begin
            rd_data_ff <= nxt_rd_data;
            rd_hit_ff  <= nxt_rd_hit;
        end
    end

    // Request follows the latches; a cleared register drops it next cycle
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |ch_irq;
        end
    end

    assign rd_data = rd_data_ff;
    assign rd_hit  = rd_hit_ff;
    assign irq_req = irq_ff;

endmodule : lasi_status_irq

// file: lasi_status_irq_checker.sv
/*
 * Port-level checker for the line status and event latch block: read
 * answers, live status, event latching and the interrupt request.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/100ps
module lasi_status_irq_checker
    import lasi_pkg::*;
#(
    parameter int NUM_CH   = 2,
    parameter int LOSS_CYC = LASI_TXCLK_LOSS_CYC
)(
    // Clock and reset
    input wire logic                       ref_clk,
    input wire logic                       rst_n,
    // Read port
    input wire logic                       rd_stb,
    input wire logic [7:0]                 rd_addr,
    input wire logic [7:0]                 rd_data,
    input wire logic                       rd_hit,
    // Line side and configuration
    input wire lasi_live_t [NUM_CH-1:0]    live_in,
    input wire logic [NUM_CH-1:0]          tx_clk_in,
    input wire lasi_pulse_t [NUM_CH-1:0]   pulse_in,
    input wire lasi_irq_cfg_t [NUM_CH-1:0] irq_cfg,
    input wire logic [NUM_CH-1:0] [7:0]    sec_mask,
    input wire logic                       irq_req
);
    // ====================
    // Helpers
    // ====================
    logic       mapped;
    logic       tx_prev_ff;
    logic [7:0] quiet_ff;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Both channel windows; a single-channel build leaves the upper one open
    assign mapped = (rd_addr >= 8'h16 && rd_addr <= 8'h19) ||
                    (NUM_CH > 1 && rd_addr >= 8'h36 && rd_addr <= 8'h39);

    // Cycles the channel one tx clock pin stayed put, saturating so it never wraps
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_prev_ff <= 1'b0;
            quiet_ff   <= 8'h00;
        end else begin
            tx_prev_ff <= tx_clk_in[0];
            quiet_ff   <= (tx_clk_in[0] != tx_prev_ff) ? 8'h00 : (quiet_ff == 8'hFF) ? quiet_ff : quiet_ff + 8'h01;
        end
    end

    // ====================
    // Sequences
    // ====================
    sequence s_live_steady;
        (live_in[0] == $past(live_in[0]))[*5];
    endsequence
    sequence s_pulse_then_read;
        (pulse_in[0] != 8'h00) ##1 (rd_stb && rd_addr == 8'h19);
    endsequence
    sequence s_double_read;
        (rd_stb && rd_addr == 8'h19 && pulse_in[0] == 8'h00) ##1 (!rd_stb && pulse_in[0] == 8'h00)
        ##1 (rd_stb && rd_addr == 8'h19 && pulse_in[0] == 8'h00);
    endsequence

    // ====================
    // Assertions
    // ====================
    a_unmapped_zero: assert property (rd_stb && !mapped |=> !rd_hit && rd_data == 8'h00)
        else $error("unmapped read gave hit or data");
    a_mapped_hit: assert property (rd_stb && mapped |=> rd_hit)
        else $error("mapped read gave no hit");
    a_reserved_zero: assert property (rd_stb && mapped && rd_addr[4:0] == 5'h17 |=> rd_data[7:6] == 2'b00)
        else $error("reserved status bits not zero");
    a_live_alarm: assert property (s_live_steady ##0 (rd_stb && rd_addr == 8'h16) |=>
        rd_data[1:0] == {$past(live_in[0].alarm_indication_seen), $past(live_in[0].signal_lost_flag)})
        else $error("alarm or loss level misread");
    a_live_atten: assert property (s_live_steady ##0 (rd_stb && rd_addr == 8'h17) |=>
        rd_data[5:0] == {$past(live_in[0].remote_loopback_active), $past(live_in[0].line_attenuation_code)})
        else $error("loopback or attenuation misread");
    a_secondary_latch: assert property (s_pulse_then_read |=>
        (rd_data & $past(pulse_in[0], 2)) == $past(pulse_in[0], 2))
        else $error("pulse event not latched");
    a_read_clears: assert property (s_double_read |=> rd_data == 8'h00)
        else $error("event register not cleared by read");
    a_pulse_irq: assert property (((pulse_in[0] & ~sec_mask[0]) != 8'h00 && !rd_stb) ##1 !rd_stb |=> irq_req)
        else $error("unmasked pulse raised no request");
    a_ais_irq: assert property (($rose(live_in[0].alarm_indication_seen) && !irq_cfg[0].mask[LASI_BIT_AIS])
        ##1 (!rd_stb)[*6] |-> irq_req)
        else $error("alarm rise raised no request");
    a_loss_set: assert property (rd_stb && rd_addr == 8'h16 && quiet_ff > LOSS_CYC + 6 |=> rd_data[LASI_BIT_TXCLK])
        else $error("stopped tx clock not flagged");
    a_loss_clear: assert property (($changed(tx_clk_in[0]))[*6] ##0 (rd_stb && rd_addr == 8'h16) |=>
        !rd_data[LASI_BIT_TXCLK])
        else $error("running tx clock flagged lost");
endmodule : lasi_status_irq_checker

bind lasi_status_irq lasi_status_irq_checker #(.NUM_CH(NUM_CH), .LOSS_CYC(LOSS_CYC)) chk_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_hit(rd_hit), .live_in(live_in), .tx_clk_in(tx_clk_in), .pulse_in(pulse_in),
    .irq_cfg(irq_cfg), .sec_mask(sec_mask), .irq_req(irq_req)
);

// file: lasi_status_irq_tb.sv
/*
 * Self-checking bench for the two-channel status and event latch block.
 * Assumes the host model for reads and a shortened tx clock loss count.
 */
`timescale 1ns/100ps
module lasi_status_irq_tb
    import lasi_pkg::*;
;
    localparam int LOSS = 8;
    logic                ref_clk;
    logic                rst_n;
    logic                rd_stb;
    logic [7:0]          rd_addr;
    logic [7:0]          rd_data;
    logic                rd_hit;
    lasi_live_t [1:0]    live_in;
    logic [1:0]          tx_clk_in;
    logic [1:0]          tx_run;
    lasi_pulse_t [1:0]   pulse_in;
    lasi_irq_cfg_t [1:0] irq_cfg;
    logic [1:0] [7:0]    sec_mask;
    logic                irq_req;
    logic [7:0]          d8;
    logic [7:0]          d9;
    logic                hit;
    int                  n_errors;
    int                  n_tests;

    lasi_status_irq #(.NUM_CH(2), .LOSS_CYC(LOSS)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_hit(rd_hit), .live_in(live_in), .tx_clk_in(tx_clk_in), .pulse_in(pulse_in),
        .irq_cfg(irq_cfg), .sec_mask(sec_mask), .irq_req(irq_req));
    lasi_host_model host_u (.ref_clk(ref_clk), .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data), .rd_hit(rd_hit));

    // 20 MHz system clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Transmit clocks toggle every cycle while running
    always @(posedge ref_clk) tx_clk_in <= tx_clk_in ^ tx_run;

    // ====================
    // Helpers
    // ====================
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wait_cyc

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // Primary bit b sits at live field b+5 above the tx slot, b+6 below it
    task automatic set_level(input logic [7:0] b, input logic v);
        live_in[0][(b > 3) ? b + 5 : b + 6] <= v;
    endtask : set_level

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    // ====================
    // Scenarios
    // ====================
    // Reset contents of both windows, then the holes beside them and the unused 8'h56
    task automatic t_reset_map;
        logic [7:0] holes [5] = '{8'h15, 8'h1A, 8'h35, 8'h3A, 8'h56};
        for (int i = 0; i < 8; i++) begin
            host_u.do_read((i < 4 ? 8'h16 : 8'h32) + i[7:0], d8, hit);
            check(d8, 8'h00);
            check({7'h00, hit}, 8'h01);
        end
        foreach (holes[i]) begin
            host_u.do_read(holes[i], d8, hit);
            check(d8, 8'h00);
            check({7'h00, hit}, 8'h00);
        end
        $display("t_reset_map done");
    endtask : t_reset_map

    // Live levels per channel, attenuation codes at zero, at the listed edge and above
    task automatic t_live;
        logic [4:0] codes [4] = '{5'h00, 5'h15, 5'h16, 5'h1F};
        foreach (codes[i]) begin
            live_in[0] <= {5'h00, i[0], ~i[0], i[1], codes[i]};
            live_in[1] <= {5'h00, ~i[0], i[0], ~i[1], ~codes[i]};
            wait_cyc(6);
            host_u.do_read(8'h16, d8, hit);
            check(d8, {6'h00, i[0], ~i[0]});
            host_u.do_read(8'h17, d8, hit);
            check(d8, {2'b00, i[1], codes[i]});
            host_u.do_read(8'h36, d8, hit);
            check(d8, {6'h00, ~i[0], i[0]});
            host_u.do_read(8'h37, d8, hit);
            check(d8, {2'b00, ~i[1], ~codes[i]});
        end
        live_in <= '0;
        wait_cyc(6);
        $display("t_live done");
    endtask : t_live

    // Level events: bits 7, 5 and 1 on any change, the rest rising only
    task automatic t_edges;
        logic [7:0] bits [7] = '{8'h07, 8'h06, 8'h05, 8'h04, 8'h02, 8'h01, 8'h00};
        irq_cfg[0] <= {8'h08, 8'hA2};
        wait_cyc(2);
        foreach (bits[i]) begin
            set_level(bits[i], 1'b1);
            wait_cyc(8);
            check({7'h00, irq_req}, 8'h01);
            host_u.service(8'h00, d8, d9);
            check(d8, 8'h01 << bits[i]);
            check(d9, 8'h00);
            wait_cyc(1);
            check({7'h00, irq_req}, 8'h00);
            set_level(bits[i], 1'b0);
            wait_cyc(8);
            host_u.do_read(8'h18, d8, hit);
            check(d8, 8'hA2 & (8'h01 << bits[i]));
        end
        irq_cfg[0] <= {8'hFF, 8'h00};
        set_level(8'h01, 1'b1);
        wait_cyc(8);
        check({7'h00, irq_req}, 8'h00);
        host_u.do_read(8'h18, d8, hit);
        check(d8, 8'h00);
        set_level(8'h01, 1'b0);
        $display("t_edges done");
    endtask : t_edges

    // Pulse events, read twice; then the secondary mask gating only the request
    task automatic t_pulses;
        for (int b = 0; b < 8; b++) begin
            pulse_in[0] <= 8'h01 << b;
            wait_cyc(1);
            pulse_in[0] <= 8'h00;
            host_u.do_read(8'h19, d8, hit);
            check(d8, 8'h01 << b);
            host_u.do_read(8'h19, d8, hit);
            check(d8, 8'h00);
        end
        pulse_in[0] <= 8'h81;
        sec_mask[1] <= 8'hFF;
        pulse_in[1] <= 8'hFF;
        wait_cyc(1);
        pulse_in <= '0;
        wait_cyc(3);
        check({7'h00, irq_req}, 8'h01);
        host_u.service(8'h00, d8, d9);
        check(d9, 8'h81);
        wait_cyc(1);
        check({7'h00, irq_req}, 8'h00);
        sec_mask[1] <= 8'h00;
        wait_cyc(3);
        check({7'h00, irq_req}, 8'h01);
        host_u.service(8'h20, d8, d9);
        check(d9, 8'hFF);
        $display("t_pulses done");
    endtask : t_pulses

    // Stopped tx clock on channel one, then restarted: rising-only event
    task automatic t_tx_loss;
        irq_cfg[0] <= {8'hF7, 8'h00};
        tx_run[0] <= 1'b0;
        wait_cyc(LOSS + 12);
        host_u.do_read(8'h16, d8, hit);
        check(d8, 8'h08);
        check({7'h00, irq_req}, 8'h01);
        host_u.service(8'h00, d8, d9);
        check(d8, 8'h08);
        tx_run[0] <= 1'b1;
        wait_cyc(8);
        host_u.do_read(8'h16, d8, hit);
        check(d8, 8'h00);
        host_u.do_read(8'h18, d8, hit);
        check(d8, 8'h00);
        $display("t_tx_loss done");
    endtask : t_tx_loss

    // Main sequence
    initial begin
        rst_n     = 1'b0;
        live_in   = '0;
        tx_clk_in = 2'b00;
        tx_run    = 2'b11;
        pulse_in  = '0;
        irq_cfg   = {2{8'hFF, 8'h00}};
        sec_mask  = '0;
        n_errors  = 0;
        n_tests   = 0;
        wait_cyc(5);
        rst_n <= 1'b1;
        wait_cyc(3);
        t_reset_map;
        t_live;
        t_edges;
        t_pulses;
        t_tx_loss;
        test_done;
    end

    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        wait_cyc(5000);
        n_errors++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        test_done;
    end
endmodule : lasi_status_irq_tb
